// file: src/rgc_cfg.svh
// Purpose: Constants for the receive gain control and status pin block
// Assumes: Included by its bare name wherever the values are needed
// Notes: Offsets are register addresses on the configuration port
`ifndef RGC_CFG_SVH
`define RGC_CFG_SVH

// Register addresses
`define RGC_ADDR_GAIN_DOWN_INIT 7'h13
`define RGC_ADDR_GAIN_UP_SENSE 7'h14
`define RGC_ADDR_STATUS_LOCK 7'h15

// Reset values: margin code 1, level 24, selector 0
`define RGC_RST_GAIN_DOWN_INIT 8'h38
`define RGC_RST_GAIN_UP_SENSE 8'h38
`define RGC_RST_STATUS_LOCK 8'h00
`define RGC_RST_GAIN 5'h18

// Threshold offsets in 1.5 dB strength steps
`define RGC_LEVEL_OFFSET 8'h08
`define RGC_DOWN_BASE 8'h03

// Status selector codes
`define RGC_SEL_ZERO 4'h0
`define RGC_SEL_ONE 4'h1
`define RGC_SEL_LOCK_STEADY 4'h2
`define RGC_SEL_LOCK_MOMENT 4'h3
`define RGC_SEL_CARRIER 4'h4
`define RGC_SEL_CAL_DONE 4'h5
`define RGC_SEL_SEQ_FAULT 4'h6
`define RGC_SEL_FIRST_TAP 4'h7

`endif

// file: src/rgc_pkg.sv
// Purpose: Types shared by the receive gain control block
// Assumes: Field positions follow the register layouts
// Notes: Structs are packed so they overlay the register bytes
package rgc_pkg;

    // Down margin and initial gain register
    typedef struct packed {
        logic [2:0] down_margin;
        logic [4:0] init_gain;
    } rgc_gain_down_type;

    // Up margin and sense level register
    typedef struct packed {
        logic [2:0] up_margin;
        logic [4:0] sense_level;
    } rgc_gain_up_type;

    // Status pin selector and lock detect settings
    typedef struct packed {
        logic [3:0] status_sel;
        logic [3:0] lock_detect;
    } rgc_status_type;

    // Gain step request
    typedef enum logic [1:0] {
        RGC_DIR_NONE = 2'b00,
        RGC_DIR_UP = 2'b01,
        RGC_DIR_DOWN = 2'b10
    } rgc_dir_type;

endpackage : rgc_pkg

// file: src/rgc_sync2.sv
// Purpose: Two flip-flop synchroniser for a vector of levels
// Assumes: Each bit is an independent slow level
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module rgc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk, // Sampling clock
    input wire logic rst_n, // Active low reset
    input wire logic [WIDTH-1:0] async_in, // Levels from other domains
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);

    logic [WIDTH-1:0] stage1;

    // Two stage capture
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : rgc_sync2

// file: src/rgc_top.sv
// Purpose: Receive gain loop thresholds, sense level and status pin selector
// Assumes: Strength samples arrive already in 1.5 dB steps on ref_clk
// Notes: Configuration port is a parallel register port on ref_clk
// Behaviour
// - Lower gain when level exceeds sense level plus 8 plus up plus 3+down.
// - Raise gain below sense level plus 8 plus up, if under maximum.
// - Thresholds compare a strength level with 1.5 dB steps.
// - Load the programmed initial gain when receive chain switches on; reset 24.
// - The gain loop never exceeds the programmed initial gain.
// - Sense level, reset 24, is the reference for carrier sense and gain.
// - Status pin follows a 4-bit selector over constants, flags and clocks.
// - With hysteresis, step only after two consecutive samples agree.
// - Average magnitude over 2, 4, 8 or 16 samples by a 2-bit code.
// - Gain loop off holds gain at the initial value.
`timescale 1ns/1ps
`include "rgc_cfg.svh"
module rgc_top
    import rgc_pkg::*;
#(
    parameter int MAG_W = 8
) (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic nrst, // Async active low reset
    input wire logic cfg_wr_en, // Register write strobe
    input wire logic cfg_rd_en, // Register read strobe
    input wire logic [6:0] cfg_addr, // Register address
    input wire logic [7:0] cfg_wdata, // Write data
    output logic [7:0] cfg_rdata, // Read data
    output logic cfg_rd_valid, // Read data valid pulse
    input wire logic rx_on, // Receive chain enabled
    input wire logic gain_loop_off, // Gain loop disabled
    input wire logic gain_step_hysteresis, // Two-sample hysteresis on
    input wire logic [1:0] magnitude_average_count, // Averaging length code
    input wire logic mag_valid, // Strength sample strobe
    input wire logic [MAG_W-1:0] mag_level, // Strength sample
    input wire logic pll_lock_steady_n, // Steady lock, active low
    input wire logic pll_lock_momentary_n, // Momentary lock, active low
    input wire logic cal_done_n, // Calibration done, active low
    input wire logic sequencing_fault_n, // Sequencing fault, active low
    input wire logic [8:0] clk_taps, // Clocks and comparators, codes 7 to 15
    output logic [4:0] vga_gain, // Amplifier gain
    output logic [7:0] strength_level, // Averaged strength
    output logic strength_valid, // Strength update pulse
    output logic carrier_sense, // Level above sense level
    output logic status_pin // Multipurpose status output
);

    logic rst_meta;
    logic rst_n;
    rgc_gain_down_type gain_cfg;
    rgc_gain_up_type up_cfg;
    rgc_status_type stat_cfg;
    rgc_dir_type pending;
    logic [12:0] sync_in;
    logic [12:0] sync_q;
    logic [11:0] acc;
    logic [3:0] cnt;
    logic rx_on_q;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Register decode
    wire wr_down = cfg_wr_en && (cfg_addr == `RGC_ADDR_GAIN_DOWN_INIT);
    wire wr_up = cfg_wr_en && (cfg_addr == `RGC_ADDR_GAIN_UP_SENSE);
    wire wr_stat = cfg_wr_en && (cfg_addr == `RGC_ADDR_STATUS_LOCK);
    wire [7:0] rd_mux = (cfg_addr == `RGC_ADDR_GAIN_DOWN_INIT) ? gain_cfg :
                        (cfg_addr == `RGC_ADDR_GAIN_UP_SENSE) ? up_cfg :
                        (cfg_addr == `RGC_ADDR_STATUS_LOCK) ? stat_cfg : 8'h00;

    // Configuration registers and read port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_cfg <= `RGC_RST_GAIN_DOWN_INIT;
            up_cfg <= `RGC_RST_GAIN_UP_SENSE;
            stat_cfg <= `RGC_RST_STATUS_LOCK;
            cfg_rdata <= 8'h00;
            cfg_rd_valid <= 1'b0;
        end else begin
            if (wr_down) gain_cfg <= cfg_wdata;
            if (wr_up) up_cfg <= cfg_wdata;
            if (wr_stat) stat_cfg <= cfg_wdata;
            cfg_rdata <= cfg_rd_en ? rd_mux : 8'h00;
            cfg_rd_valid <= cfg_rd_en;
        end
    end

    // Averaging length and sum
    wire [3:0] avg_last = 4'((5'h02 << magnitude_average_count) - 5'h01);
    wire [11:0] acc_sum = acc + 12'(mag_level);
    wire [11:0] avg_val = acc_sum >> (3'(magnitude_average_count) + 3'h1); // Three bits so code 3 shifts by 4
    wire avg_done = mag_valid && (cnt == avg_last);

    // Magnitude averager; level is in 1.5 dB steps
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 12'h000;
            cnt <= 4'h0;
            strength_level <= 8'h00;
            strength_valid <= 1'b0;
            carrier_sense <= 1'b0;
        end else begin
            strength_valid <= avg_done;
            if (mag_valid) begin
                acc <= avg_done ? 12'h000 : acc_sum;
                cnt <= avg_done ? 4'h0 : cnt + 4'h1;
            end
            if (avg_done) begin
                strength_level <= avg_val[7:0];
                carrier_sense <= avg_val[7:0] > {3'h0, up_cfg.sense_level};
            end
        end
    end

    // Thresholds in strength steps
    wire [7:0] up_th = {3'h0, up_cfg.sense_level} + `RGC_LEVEL_OFFSET + {5'h00, up_cfg.up_margin};
    wire [7:0] down_th = up_th + `RGC_DOWN_BASE + {5'h00, gain_cfg.down_margin};
    wire at_max = vga_gain >= gain_cfg.init_gain;
    wire want_down = (strength_level > down_th) && (vga_gain != 5'h00);
    wire want_up = (strength_level < up_th) && !at_max;
    wire rgc_dir_type want = want_down ? RGC_DIR_DOWN : (want_up ? RGC_DIR_UP : RGC_DIR_NONE);
    wire step_ok = !gain_step_hysteresis || (pending == want);
    wire rx_rise = rx_on && !rx_on_q;
    wire [4:0] stepped = (want == RGC_DIR_UP) ? vga_gain + 5'h01 :
                         (want == RGC_DIR_DOWN) ? vga_gain - 5'h01 : vga_gain;
    wire [4:0] loop_gain = (strength_valid && step_ok) ? stepped : vga_gain;
    wire [4:0] next_gain = (rx_rise || gain_loop_off) ? gain_cfg.init_gain :
                           (loop_gain > gain_cfg.init_gain) ? gain_cfg.init_gain : loop_gain;

    // Gain register and hysteresis memory
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vga_gain <= `RGC_RST_GAIN;
            pending <= RGC_DIR_NONE;
            rx_on_q <= 1'b0;
        end else begin
            vga_gain <= next_gain;
            rx_on_q <= rx_on;
            if (rx_rise || gain_loop_off) begin
                pending <= RGC_DIR_NONE;
            end else if (strength_valid) begin
                pending <= (step_ok || want == RGC_DIR_NONE) ? RGC_DIR_NONE : want;
            end
        end
    end

    // Outside flags pass two flops before selection
    assign sync_in = {clk_taps, sequencing_fault_n, cal_done_n, pll_lock_momentary_n, pll_lock_steady_n};

    rgc_sync2 #(
        .WIDTH(13)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(sync_in),
        .sync_out(sync_q)
    );

    // Status pin selection; code 2 is the lock indicator the host picks
    wire [3:0] sel = stat_cfg.status_sel;
    wire [3:0] tap_idx = sel - `RGC_SEL_FIRST_TAP;
    wire next_status = (sel == `RGC_SEL_ZERO) ? 1'b0 :
                       (sel == `RGC_SEL_ONE) ? 1'b1 :
                       (sel == `RGC_SEL_LOCK_STEADY) ? sync_q[0] :
                       (sel == `RGC_SEL_LOCK_MOMENT) ? sync_q[1] :
                       (sel == `RGC_SEL_CARRIER) ? !carrier_sense :
                       (sel == `RGC_SEL_CAL_DONE) ? sync_q[2] :
                       (sel == `RGC_SEL_SEQ_FAULT) ? sync_q[3] : sync_q[4 + tap_idx];

    // Status pin flop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_pin <= 1'b0;
        end else begin
            status_pin <= next_status;
        end
    end

    // Checks on the gain loop, averager, carrier sense and status pin
    wire loop_free = strength_valid && !rx_rise && !gain_loop_off && (vga_gain <= gain_cfg.init_gain);

    a_gain_down_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loop_free && !gain_step_hysteresis && (strength_level > down_th) && (vga_gain != 5'h00)
        |=> vga_gain == $past(vga_gain) - 5'h01)
        else $error("gain not lowered above down threshold");

    a_gain_up_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loop_free && !gain_step_hysteresis && (strength_level < up_th) && (vga_gain < gain_cfg.init_gain)
        |=> vga_gain == $past(vga_gain) + 5'h01)
        else $error("gain not raised below up threshold");

    a_rx_on_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_on && !rx_on_q |=> vga_gain == $past(gain_cfg.init_gain))
        else $error("initial gain not loaded at receive start");

    a_gain_ceiling: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> vga_gain <= $past(gain_cfg.init_gain))
        else $error("gain above ceiling");

    a_sense_ref: assert property (@(posedge ref_clk) disable iff (!rst_n)
        avg_done |=> carrier_sense == (strength_level > {3'h0, $past(up_cfg.sense_level)}))
        else $error("carrier sense not against sense level");

    a_status_const: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sel == `RGC_SEL_ZERO || sel == `RGC_SEL_ONE) |=> status_pin == $past(sel[0]))
        else $error("status pin constant wrong");

    a_hyst_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loop_free && gain_step_hysteresis && (want != RGC_DIR_NONE) && (pending != want)
        |=> $stable(vga_gain) && (pending == $past(want)))
        else $error("hysteresis stepped on one sample");

    a_avg_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mag_valid && (cnt == 4'h0) && (magnitude_average_count == 2'h0) ##1 mag_valid
        |=> strength_valid)
        else $error("two-sample average not produced");

    a_loop_off_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        gain_loop_off [*2] |-> vga_gain == $past(gain_cfg.init_gain))
        else $error("gain moved with loop off");

    a_band_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loop_free && (strength_level >= up_th) && (strength_level <= down_th) |=> $stable(vga_gain))
        else $error("gain changed inside band");

endmodule : rgc_top

// file: test/rgc_host_model.sv
// Purpose: Host model driving the configuration register port
// Assumes: Requests launched on falling edges and held across one rising edge
// Notes: Released address and data show the inverse of the last value
`timescale 1ns/1ps
module rgc_host_model (
    input wire logic ref_clk, // Port clock
    output logic cfg_wr_en, // Write strobe
    output logic cfg_rd_en, // Read strobe
    output logic [6:0] cfg_addr, // Register address
    output logic [7:0] cfg_wdata, // Write data
    input wire logic [7:0] cfg_rdata, // Read data
    input wire logic cfg_rd_valid // Read data valid
);
    // Idle port at time zero
    initial begin
        cfg_wr_en = 1'b0;
        cfg_rd_en = 1'b0;
        cfg_addr = 7'h00;
        cfg_wdata = 8'h00;
    end

    // One-cycle write strobe
    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        cfg_addr = addr;
        cfg_wdata = data;
        cfg_wr_en = 1'b1;
        @(negedge ref_clk);
        cfg_wr_en = 1'b0;
        cfg_addr = ~addr;
        cfg_wdata = ~data;
    endtask : wr

    // Read strobe; answer stands in the following cycle
    task automatic rd(input logic [6:0] addr, output logic [7:0] data, output logic valid);
        @(negedge ref_clk);
        cfg_addr = addr;
        cfg_rd_en = 1'b1;
        @(negedge ref_clk);
        cfg_rd_en = 1'b0;
        cfg_addr = ~addr;
        data = cfg_rdata;
        valid = cfg_rd_valid;
    endtask : rd

    // Route steady lock to the status pin
    task automatic use_lock_pin();
        wr(7'h15, 8'h20);
    endtask : use_lock_pin
endmodule : rgc_host_model

// file: test/rgc_top_tb.sv
// Purpose: Self-checking bench for the gain thresholds and status pin
// Assumes: Host model owns the register port; bench drives the rest
// Notes: Every average adds N to its first sample so the mean is exact
`timescale 1ns/1ps
`include "rgc_cfg.svh"
module rgc_top_tb;
    logic ref_clk, nrst, rx_on, gain_loop_off, gain_step_hysteresis, mag_valid, rd_valid;
    logic cfg_wr_en, cfg_rd_en, cfg_rd_valid, strength_valid, carrier_sense, status_pin;
    logic pll_lock_steady_n, pll_lock_momentary_n, cal_done_n, sequencing_fault_n;
    logic [1:0] magnitude_average_count;
    logic [6:0] cfg_addr;
    logic [7:0] cfg_wdata, cfg_rdata, mag_level, strength_level, rd_data, sense;
    logic [8:0] clk_taps;
    logic [4:0] vga_gain;
    logic [15:0] src_map;
    int failures = 0;
    int tests_run = 0;
    int sv_cnt = 0;

    // Expected pin per selector code, carrier idle
    assign src_map = {clk_taps, sequencing_fault_n, cal_done_n, 1'b1, pll_lock_momentary_n,
                      pll_lock_steady_n, 2'b10};

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Count strength pulses
    always @(posedge ref_clk) begin
        if (strength_valid === 1'b1) sv_cnt <= sv_cnt + 1;
    end

    rgc_host_model u_host (.ref_clk(ref_clk), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid));

    rgc_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
        .rx_on(rx_on), .gain_loop_off(gain_loop_off), .gain_step_hysteresis(gain_step_hysteresis),
        .magnitude_average_count(magnitude_average_count), .mag_valid(mag_valid), .mag_level(mag_level),
        .pll_lock_steady_n(pll_lock_steady_n), .pll_lock_momentary_n(pll_lock_momentary_n),
        .cal_done_n(cal_done_n), .sequencing_fault_n(sequencing_fault_n), .clk_taps(clk_taps),
        .vga_gain(vga_gain), .strength_level(strength_level), .strength_valid(strength_valid),
        .carrier_sense(carrier_sense), .status_pin(status_pin));

    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Read a register and compare
    task automatic check_reg(input logic [6:0] addr, input logic [7:0] exp);
        u_host.rd(addr, rd_data, rd_valid);
        check("read valid", {7'h00, rd_valid}, 8'h01);
        check("read data", rd_data, exp);
    endtask : check_reg

    // One average of 2<<code samples with mean lvl, then gain check
    task automatic avg(input logic [1:0] code, input logic [7:0] lvl, input logic [4:0] gain);
        int n;
        int start;
        n = 2 << code;
        start = sv_cnt;
        @(negedge ref_clk);
        magnitude_average_count = code;
        for (int i = 0; i < n; i++) begin
            mag_valid = 1'b1;
            mag_level = (i == 0) ? lvl - 8'h01 + 8'(n) : lvl - 8'h01;
            @(negedge ref_clk);
        end
        mag_valid = 1'b0;
        mag_level = ~mag_level;
        repeat (2) @(negedge ref_clk);
        check("average count", 8'(sv_cnt - start), 8'h01);
        check("strength level", strength_level, lvl);
        check("carrier sense", {7'h00, carrier_sense}, {7'h00, lvl > sense});
        check("gain", {3'h0, vga_gain}, {3'h0, gain});
    endtask : avg

    // Verdict and end of run
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test

    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end

    // Main sequence
    initial begin
        nrst = 1'b0;
        {rx_on, gain_loop_off, gain_step_hysteresis, mag_valid} = 4'h0;
        magnitude_average_count = 2'h0;
        mag_level = 8'h00;
        {pll_lock_steady_n, pll_lock_momentary_n, cal_done_n, sequencing_fault_n} = 4'hF;
        clk_taps = 9'h000;
        sense = 8'h18;
        repeat (20) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (3) @(negedge ref_clk);
        check("reset gain", {3'h0, vga_gain}, 8'h18);
        check_reg(`RGC_ADDR_GAIN_DOWN_INIT, 8'h38);
        check_reg(`RGC_ADDR_GAIN_UP_SENSE, 8'h38);
        check_reg(`RGC_ADDR_STATUS_LOCK, 8'h00);
        u_host.wr(7'h16, 8'hFF);
        check_reg(7'h16, 8'h00);
        // Every selector code with both source patterns
        for (int k = 0; k < 16; k++) begin
            u_host.wr(`RGC_ADDR_STATUS_LOCK, {4'(k), 4'h5});
            check_reg(`RGC_ADDR_STATUS_LOCK, {4'(k), 4'h5});
            for (int p = 0; p < 2; p++) begin
                {pll_lock_steady_n, cal_done_n} = {2{p[0]}};
                {pll_lock_momentary_n, sequencing_fault_n} = {2{~p[0]}};
                clk_taps = p[0] ? 9'h0AA : 9'h155;
                repeat (4) @(negedge ref_clk);
                check("status pin", {7'h00, status_pin}, {7'h00, src_map[k]});
            end
        end
        u_host.use_lock_pin();
        pll_lock_steady_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("lock pin", {7'h00, status_pin}, 8'h00);
        // Thresholds: up 18, down 21
        sense = 8'h0A;
        u_host.wr(`RGC_ADDR_GAIN_UP_SENSE, 8'h0A);
        u_host.wr(`RGC_ADDR_GAIN_DOWN_INIT, 8'h14);
        rx_on = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("gain on", {3'h0, vga_gain}, 8'h14);
        avg(2'h0, 8'd22, 5'd19);
        avg(2'h0, 8'd21, 5'd19);
        avg(2'h0, 8'd18, 5'd19);
        avg(2'h0, 8'd17, 5'd20);
        avg(2'h0, 8'd17, 5'd20);
        avg(2'h0, 8'd30, 5'd19);
        rx_on = 1'b0;
        @(negedge ref_clk);
        rx_on = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("gain reload", {3'h0, vga_gain}, 8'h14);
        // Down margin 7: down threshold 28
        u_host.wr(`RGC_ADDR_GAIN_DOWN_INIT, 8'hF4);
        avg(2'h0, 8'd28, 5'd20);
        avg(2'h0, 8'd29, 5'd19);
        // Up margin 2: up 20, down 30
        u_host.wr(`RGC_ADDR_GAIN_UP_SENSE, 8'h4A);
        avg(2'h0, 8'd19, 5'd20);
        gain_step_hysteresis = 1'b1;
        avg(2'h0, 8'd25, 5'd20);
        avg(2'h0, 8'd31, 5'd20);
        avg(2'h0, 8'd31, 5'd19);
        avg(2'h0, 8'd19, 5'd19);
        avg(2'h0, 8'd19, 5'd20);
        gain_step_hysteresis = 1'b0;
        avg(2'h0, 8'd31, 5'd19);
        gain_loop_off = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("gain held", {3'h0, vga_gain}, 8'h14);
        avg(2'h0, 8'd31, 5'd20);
        gain_loop_off = 1'b0;
        // Lower ceiling to 15, down margin kept at 7
        u_host.wr(`RGC_ADDR_GAIN_DOWN_INIT, 8'hEF);
        repeat (2) @(negedge ref_clk);
        check("gain clamp", {3'h0, vga_gain}, 8'h0F);
        avg(2'h0, 8'd5, 5'd15);
        for (int c = 0; c < 4; c++) avg(2'(c), 8'd25, 5'd15);
        end_of_test();
    end
endmodule : rgc_top_tb
